// [fls_freq_seq.sv]
`timescale 1ns/10ps
// How it works
// - high and low frequency limits are writable from 0 to 500.0 Hz
// - V/f: high clamps output, low clamps reference; vector: both clamp reference
// - reference clamping may let the delivered frequency briefly overshoot
// - on decelerate-to-stop, inject DC brake once output reaches brake start
// - brake time is 0.01 to 30.00 s; zero disables timed braking
// - brake start frequency ranges 0.0 to 60.0 Hz
// - brake level in 1% steps, at most 100% heavy duty, 80% otherwise
// - brake response 0 slow, 1 quick; fixed under vector control
// - brake enable input holds braking on regardless of brake time
// - brake enable input while stopped starts braking for pre-excitation
// - V/f start begins at start frequency; output stops at stop frequency
// - start frequency is held 0.00 to 10.00 s before accelerating
// - stop frequency is held 0.00 to 10.00 s before output shuts off
// - start frequency 0.0 to 60.0 Hz; zero acts as 0.1 Hz under V/f
// - stop frequency 0.0 to 60.0 Hz; zero acts as 0.1 Hz under V/f
// - start below stop: no output until reference exceeds stop frequency
module fls_freq_seq
  import fls_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYCLES_DEF
) (
  input wire logic sys_clk, // 250 MHz system clock
  input wire logic reset, // async, active high
  input wire logic runCmd, // run command pin, async
  input wire logic brakeEnableInput, // DC brake enable pin, async
  input wire logic [15:0] refFreq, // reference, 0.1 Hz, same clock
  output logic [15:0] outFreq, // commanded output frequency, 0.1 Hz
  output logic gateOn, // inverter output enabled
  output logic brakeActive, // DC brake current injected
  output logic [6:0] brakeLevel, // brake current, percent of rated
  output logic brakeQuick, // quick current rise
  input wire logic [7:0] s_axi_awaddr, // write address
  input wire logic s_axi_awvalid, // write address valid
  output logic s_axi_awready, // write address ready
  input wire logic [31:0] s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb, // byte enables
  input wire logic s_axi_wvalid, // write data valid
  output logic s_axi_wready, // write data ready
  output logic [1:0] s_axi_bresp, // write response
  output logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  input wire logic [7:0] s_axi_araddr, // read address
  input wire logic s_axi_arvalid, // read address valid
  output logic s_axi_arready, // read address ready
  output logic [31:0] s_axi_rdata, // read data
  output logic [1:0] s_axi_rresp, // read response
  output logic s_axi_rvalid, // read data valid
  input wire logic s_axi_rready // read data ready
);

  fls_st_t s_ff;
  fls_st_t nxt_s;
  logic tick;

  if (TICK_CYCLES < 1) begin : g_chk
    $error("TICK_CYCLES must be at least one");
  end

  fls_tick_div #(.CYCLES(TICK_CYCLES)) u_tick (
    .sys_clk(sys_clk),
    .reset(reset),
    .tick(tick)
  );

  function automatic logic [15:0] clipF(input logic [31:0] v, input logic [15:0] mx);
    clipF = (v > {16'h0000, mx}) ? mx : v[15:0];
  endfunction

  function automatic logic [11:0] clipT(input logic [31:0] v, input logic [11:0] mx);
    clipT = (v > {20'h00000, mx}) ? mx : v[11:0];
  endfunction

  // moves cur toward tgt by at most step
  function automatic logic [15:0] ramp(input logic [15:0] cur, input logic [15:0] tgt,
                                       input logic [15:0] step);
    if (cur < tgt) begin
      ramp = ((tgt - cur) > step) ? cur + step : tgt;
    end else begin
      ramp = ((cur - tgt) > step) ? cur - step : tgt;
    end
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    for (int i = 0; i < 4; i++) begin
      merge[8*i +: 8] = strb[i] ? nw[8*i +: 8] : old[8*i +: 8];
    end
  endfunction

  // settings as the sequencer sees them
  logic vec;
  logic [15:0] startEff;
  logic [15:0] stopEff;
  logic [15:0] startOut;
  logic [15:0] refHi;
  logic [15:0] refMax;
  logic [15:0] refLim;
  logic [6:0] lvlMax;
  logic stopping;
  logic startOk;
  logic timerDoneW;

  assign vec = s_ff.cfg.ctrl[CTRL_VECTOR];
  // V/f never starts or stops at a true zero
  assign startEff = (!vec && s_ff.cfg.startFreq == FREQ_ZERO) ? VF_MIN_FREQ
                                                              : s_ff.cfg.startFreq;
  assign stopEff = (!vec && s_ff.cfg.stopFreq == FREQ_ZERO) ? VF_MIN_FREQ
                                                            : s_ff.cfg.stopFreq;
  // V/f output high clamp also bounds the start step
  assign startOut = (!vec && startEff > s_ff.cfg.highLim) ? s_ff.cfg.highLim : startEff;
  // vector control clamps the reference at the high limit; the loop may overshoot
  assign refHi = (vec && refFreq > s_ff.cfg.highLim) ? s_ff.cfg.highLim : refFreq;
  assign refMax = (refHi > s_ff.cfg.maxFreq) ? s_ff.cfg.maxFreq : refHi;
  // low limit always acts on the reference; mode bit chooses stop instead of clamp
  assign refLim = (refMax >= s_ff.cfg.lowLim) ? refMax
                : (s_ff.cfg.ctrl[CTRL_LOWMODE] ? FREQ_ZERO : s_ff.cfg.lowLim);
  assign lvlMax = s_ff.cfg.ctrl[CTRL_HEAVY] ? LVL_HEAVY_MAX : LVL_MED_MAX;
  assign stopping = !s_ff.runSync || (refLim < stopEff);
  // starting below stop needs the reference above stop as well
  assign startOk = s_ff.runSync && refLim >= startEff
                   && (startEff >= stopEff || refLim > stopEff);

  // register read mux; unused bits read zero
  function automatic logic [31:0] rdMux(input fls_st_t st, input logic [7:0] a);
    rdMux = 32'h00000000;
    case (a)
      OFS_CTRL: rdMux = {28'h0000000, st.cfg.ctrl};
      OFS_HIGH_LIM: rdMux = {16'h0000, st.cfg.highLim};
      OFS_LOW_LIM: rdMux = {16'h0000, st.cfg.lowLim};
      OFS_MAX_FREQ: rdMux = {16'h0000, st.cfg.maxFreq};
      OFS_BRK_START: rdMux = {16'h0000, st.cfg.brkStart};
      OFS_BRK_LEVEL: rdMux = {25'h0000000, st.cfg.brkLevel};
      OFS_BRK_TIME: rdMux = {20'h00000, st.cfg.brkTime};
      OFS_START_FREQ: rdMux = {16'h0000, st.cfg.startFreq};
      OFS_START_HOLD: rdMux = {20'h00000, st.cfg.startHold};
      OFS_STOP_FREQ: rdMux = {16'h0000, st.cfg.stopFreq};
      OFS_STOP_HOLD: rdMux = {20'h00000, st.cfg.stopHold};
      OFS_RAMP_STEP: rdMux = {16'h0000, st.cfg.rampStep};
      // state [22:20], gateOn [19], brakeOn [18], outFreq [15:0]
      OFS_STATUS: rdMux = {9'h000, st.state, st.gateOn, st.brakeOn,
                           2'h0, st.outFreq};
      default: rdMux = 32'h00000000;
    endcase
  endfunction

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a[1:0] == 2'h0) && (a <= OFS_STATUS);
  endfunction

  // next-state logic: bus slave, synchronisers and sequencer
  always_comb begin
    logic [31:0] wv;
    logic [15:0] tgt;
    logic timerDone;
    nxt_s = s_ff;
    wv = 32'h00000000;
    tgt = FREQ_ZERO;
    timerDone = (s_ff.timer == TIME_ZERO);
    nxt_s.runMeta = runCmd;
    nxt_s.runSync = s_ff.runMeta;
    nxt_s.brkMeta = brakeEnableInput;
    nxt_s.brkSync = s_ff.brkMeta;

    // write channel: address and data taken in either order
    if (s_axi_awvalid && s_ff.awRdy) begin
      nxt_s.awHeld = 1'b1;
      nxt_s.awAddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_ff.wRdy) begin
      nxt_s.wHeld = 1'b1;
      nxt_s.wData = s_axi_wdata;
      nxt_s.wStrb = s_axi_wstrb;
    end
    if (s_ff.bValid && s_axi_bready) begin
      nxt_s.bValid = 1'b0;
    end
    if (s_ff.awHeld && s_ff.wHeld && !s_ff.bValid) begin
      nxt_s.awHeld = 1'b0;
      nxt_s.wHeld = 1'b0;
      nxt_s.bValid = 1'b1;
      nxt_s.bResp = (mapped(s_ff.awAddr) && s_ff.awAddr != OFS_STATUS) ? RESP_OKAY
                                                                       : RESP_SLVERR;
      wv = merge(rdMux(s_ff, s_ff.awAddr), s_ff.wData, s_ff.wStrb);
      // writes saturate to each setting's range; ctrl and rampStep keep only their low bits
      case (s_ff.awAddr)
        OFS_CTRL: nxt_s.cfg.ctrl = wv[3:0];
        OFS_HIGH_LIM: nxt_s.cfg.highLim = clipF(wv, FREQ_LIM_MAX);
        OFS_LOW_LIM: nxt_s.cfg.lowLim = clipF(wv, FREQ_LIM_MAX);
        OFS_MAX_FREQ: nxt_s.cfg.maxFreq = clipF(wv, FREQ_LIM_MAX);
        OFS_BRK_START: nxt_s.cfg.brkStart = clipF(wv, SETUP_FREQ_MAX);
        OFS_BRK_LEVEL: nxt_s.cfg.brkLevel = (wv > {25'h0000000, LVL_HEAVY_MAX}) ? LVL_HEAVY_MAX
                                                                              : wv[6:0];
        OFS_BRK_TIME: nxt_s.cfg.brkTime = clipT(wv, BRK_TIME_MAX);
        OFS_START_FREQ: nxt_s.cfg.startFreq = clipF(wv, SETUP_FREQ_MAX);
        OFS_START_HOLD: nxt_s.cfg.startHold = clipT(wv, HOLD_MAX);
        OFS_STOP_FREQ: nxt_s.cfg.stopFreq = clipF(wv, SETUP_FREQ_MAX);
        OFS_STOP_HOLD: nxt_s.cfg.stopHold = clipT(wv, HOLD_MAX);
        OFS_RAMP_STEP: nxt_s.cfg.rampStep = wv[15:0];
        default: nxt_s.cfg = s_ff.cfg;
      endcase
    end
    // hold ready low while a beat waits, so a second one is never lost
    nxt_s.awRdy = !nxt_s.awHeld;
    nxt_s.wRdy = !nxt_s.wHeld;

    // read channel: one read in flight, answered the cycle after the address
    if (s_ff.rValid && s_axi_rready) begin
      nxt_s.rValid = 1'b0;
    end
    if (s_axi_arvalid && s_ff.arRdy) begin
      nxt_s.rValid = 1'b1;
      nxt_s.rData = rdMux(s_ff, s_axi_araddr);
      nxt_s.rResp = mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
    end
    nxt_s.arRdy = !nxt_s.rValid;

    // timer counts 0.01 s ticks
    if (tick && !timerDone) begin
      nxt_s.timer = s_ff.timer - 1'b1;
    end

    // sequencer
    case (s_ff.state)
      ST_IDLE: begin
        nxt_s.outFreq = FREQ_ZERO;
        nxt_s.timer = TIME_ZERO;
        if (s_ff.brkSync) begin
          nxt_s.state = ST_BRAKE;
        end else if (startOk) begin
          nxt_s.state = ST_START;
          nxt_s.timer = s_ff.cfg.startHold;
          nxt_s.outFreq = vec ? FREQ_ZERO : startOut;
        end
      end
      ST_START: begin
        // vector control ramps up to the start frequency before holding
        if (tick) begin
          nxt_s.outFreq = ramp(s_ff.outFreq, startOut, s_ff.cfg.rampStep);
        end
        if (s_ff.outFreq != startOut) begin
          nxt_s.timer = s_ff.timer;
        end
        if ((timerDone && s_ff.outFreq == startOut) || stopping) begin
          nxt_s.state = ST_RUN;
        end
      end
      ST_RUN: begin
        tgt = stopping ? FREQ_ZERO : refLim;
        if (tick) begin
          nxt_s.outFreq = ramp(s_ff.outFreq, tgt, s_ff.cfg.rampStep);
        end
        if (stopping && s_ff.brkSync) begin
          nxt_s.state = ST_BRAKE;
          nxt_s.timer = TIME_ZERO;
        end else if (stopping && s_ff.cfg.brkTime != TIME_ZERO
                     && s_ff.outFreq <= s_ff.cfg.brkStart && s_ff.outFreq > stopEff) begin
          nxt_s.state = ST_BRAKE;
          nxt_s.timer = s_ff.cfg.brkTime;
        end else if (stopping && s_ff.outFreq <= stopEff) begin
          nxt_s.state = ST_STOP_HOLD;
          nxt_s.timer = s_ff.cfg.stopHold;
          nxt_s.outFreq = s_ff.outFreq;
        end
      end
      ST_STOP_HOLD: begin
        if (!stopping) begin
          nxt_s.state = ST_RUN;
        end else if (timerDone) begin
          // brake start below stop frequency still brakes after the hold
          nxt_s.state = (s_ff.cfg.brkTime != TIME_ZERO) ? ST_BRAKE : ST_IDLE;
          nxt_s.timer = s_ff.cfg.brkTime;
          nxt_s.outFreq = FREQ_ZERO;
        end
      end
      ST_BRAKE: begin
        nxt_s.outFreq = FREQ_ZERO;
        // the external input overrides the programmed time
        if (timerDone && !s_ff.brkSync) begin
          nxt_s.state = ST_IDLE;
        end
      end
      default: begin
        nxt_s.state = ST_IDLE;
        nxt_s.outFreq = FREQ_ZERO;
      end
    endcase

    // V/f: the high limit bounds the output itself
    if (!vec && nxt_s.outFreq > s_ff.cfg.highLim) begin
      nxt_s.outFreq = s_ff.cfg.highLim;
    end
    nxt_s.gateOn = (nxt_s.state != ST_IDLE);
    nxt_s.brakeOn = (nxt_s.state == ST_BRAKE);
    // level written in 1% steps; medium/light duty caps it lower
    nxt_s.brakeLevel = (s_ff.cfg.brkLevel > lvlMax) ? lvlMax : s_ff.cfg.brkLevel;
    nxt_s.brakeQuick = vec ? RESP_VECTOR_FIXED : s_ff.cfg.ctrl[CTRL_RESP];
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      s_ff <= '0;
      s_ff.cfg.ctrl <= RST_CTRL;
      s_ff.cfg.highLim <= RST_HIGH_LIM;
      s_ff.cfg.maxFreq <= RST_MAX_FREQ;
      s_ff.cfg.startFreq <= RST_START_FREQ;
      s_ff.cfg.stopFreq <= RST_STOP_FREQ;
      s_ff.cfg.rampStep <= RST_RAMP_STEP;
      s_ff.state <= ST_IDLE;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign outFreq = s_ff.outFreq;
  assign gateOn = s_ff.gateOn;
  assign brakeActive = s_ff.brakeOn;
  assign brakeLevel = s_ff.brakeLevel;
  assign brakeQuick = s_ff.brakeQuick;
  assign s_axi_awready = s_ff.awRdy;
  assign s_axi_wready = s_ff.wRdy;
  assign s_axi_bvalid = s_ff.bValid;
  assign s_axi_bresp = s_ff.bResp;
  assign s_axi_arready = s_ff.arRdy;
  assign s_axi_rvalid = s_ff.rValid;
  assign s_axi_rdata = s_ff.rData;
  assign s_axi_rresp = s_ff.rResp;

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (reset);

  // settings never leave their ranges
  a_limit_range: assert property (s_ff.cfg.highLim <= FREQ_LIM_MAX
    && s_ff.cfg.lowLim <= FREQ_LIM_MAX && s_ff.cfg.brkTime <= BRK_TIME_MAX
    && s_ff.cfg.brkStart <= SETUP_FREQ_MAX && s_ff.cfg.startHold <= HOLD_MAX
    && s_ff.cfg.stopHold <= HOLD_MAX)
    else $error("setting out of range");
  a_vf_high_clamp: assert property (!vec ##1 !vec |-> s_ff.outFreq <= $past(s_ff.cfg.highLim))
    else $error("V/f output above high limit");
  a_low_clamp: assert property (!s_ff.cfg.ctrl[CTRL_LOWMODE] |-> refLim >= s_ff.cfg.lowLim
    || s_ff.cfg.maxFreq < s_ff.cfg.lowLim)
    else $error("reference below low limit");
  a_brake_level_cap: assert property (s_ff.brakeOn |-> s_ff.brakeLevel <= LVL_HEAVY_MAX
    && (s_ff.cfg.ctrl[CTRL_HEAVY] || $past(s_ff.cfg.ctrl[CTRL_HEAVY])
    || s_ff.brakeLevel <= LVL_MED_MAX))
    else $error("brake level above cap");
  a_vector_resp: assert property (vec |=> s_ff.brakeQuick == RESP_VECTOR_FIXED)
    else $error("vector brake response not fixed");
  a_ext_brake_hold: assert property (s_ff.state == ST_BRAKE && s_ff.brkSync
    |=> s_ff.state == ST_BRAKE && s_ff.brakeOn)
    else $error("brake dropped while input held");
  a_idle_prebrake: assert property (s_ff.state == ST_IDLE && s_ff.brkSync
    |=> s_ff.state == ST_BRAKE && s_ff.brakeOn)
    else $error("pre-excitation brake not entered");
  a_brake_cause: assert property ($rose(s_ff.brakeOn) |->
    $past(s_ff.cfg.brkTime) != TIME_ZERO || $past(s_ff.brkSync))
    else $error("timed brake with zero time");
  a_vf_start_freq: assert property (s_ff.state == ST_IDLE && startOk && !s_ff.brkSync
    && !vec |=> s_ff.outFreq == $past(startOut) && s_ff.outFreq != FREQ_ZERO)
    else $error("V/f start not at start frequency");
  a_start_hold: assert property (s_ff.state == ST_START && !timerDoneW && !stopping
    |=> s_ff.state == ST_START)
    else $error("start hold cut short");
  a_no_early_out: assert property (s_ff.state == ST_IDLE && refLim <= stopEff
    && startEff < stopEff |=> s_ff.state != ST_START)
    else $error("output started below stop frequency");

  assign timerDoneW = (s_ff.timer == TIME_ZERO);
endmodule

// [fls_pkg.sv]
package fls_pkg;

  // register map, byte addresses on the AXI4-Lite slave
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_HIGH_LIM = 8'h04;
  localparam logic [7:0] OFS_LOW_LIM = 8'h08;
  localparam logic [7:0] OFS_MAX_FREQ = 8'h0C;
  localparam logic [7:0] OFS_BRK_START = 8'h10;
  localparam logic [7:0] OFS_BRK_LEVEL = 8'h14;
  localparam logic [7:0] OFS_BRK_TIME = 8'h18;
  localparam logic [7:0] OFS_START_FREQ = 8'h1C;
  localparam logic [7:0] OFS_START_HOLD = 8'h20;
  localparam logic [7:0] OFS_STOP_FREQ = 8'h24;
  localparam logic [7:0] OFS_STOP_HOLD = 8'h28;
  localparam logic [7:0] OFS_RAMP_STEP = 8'h2C;
  localparam logic [7:0] OFS_STATUS = 8'h30;

  // control register bit positions
  localparam int CTRL_VECTOR = 0;
  localparam int CTRL_HEAVY = 1;
  localparam int CTRL_RESP = 2;
  localparam int CTRL_LOWMODE = 3;

  // frequencies in 0.1 Hz, times in 0.01 s, level in percent
  localparam logic [15:0] FREQ_ZERO = 16'h0000;
  localparam logic [15:0] FREQ_LIM_MAX = 16'h1388;
  localparam logic [15:0] SETUP_FREQ_MAX = 16'h0258;
  localparam logic [15:0] VF_MIN_FREQ = 16'h0001;
  localparam logic [11:0] BRK_TIME_MAX = 12'hBB8;
  localparam logic [11:0] HOLD_MAX = 12'h3E8;
  localparam logic [11:0] TIME_ZERO = 12'h000;
  localparam logic [6:0] LVL_HEAVY_MAX = 7'h64;
  localparam logic [6:0] LVL_MED_MAX = 7'h50;
  localparam logic RESP_VECTOR_FIXED = 1'b1;

  // time base: one tick per 0.01 s
  localparam int TIME_UNIT_NS = 10000000;
  localparam int CLK_PERIOD_NS = 4;
  localparam int TICK_CYCLES_DEF = TIME_UNIT_NS / CLK_PERIOD_NS;

  // reset values
  localparam logic [3:0] RST_CTRL = 4'h0;
  localparam logic [15:0] RST_HIGH_LIM = 16'h1388;
  localparam logic [15:0] RST_MAX_FREQ = 16'h1388;
  localparam logic [15:0] RST_START_FREQ = 16'h0005;
  localparam logic [15:0] RST_STOP_FREQ = 16'h0002;
  localparam logic [15:0] RST_RAMP_STEP = 16'h000A;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_START = 3'b001,
    ST_RUN = 3'b010,
    ST_STOP_HOLD = 3'b011,
    ST_BRAKE = 3'b100
  } fls_state_t;

  typedef struct packed {
    logic [3:0] ctrl;
    logic [15:0] highLim;
    logic [15:0] lowLim;
    logic [15:0] maxFreq;
    logic [15:0] brkStart;
    logic [6:0] brkLevel;
    logic [11:0] brkTime;
    logic [15:0] startFreq;
    logic [11:0] startHold;
    logic [15:0] stopFreq;
    logic [11:0] stopHold;
    logic [15:0] rampStep;
  } fls_cfg_t;

  typedef struct packed {
    fls_cfg_t cfg;
    logic runMeta;
    logic runSync;
    logic brkMeta;
    logic brkSync;
    fls_state_t state;
    logic [15:0] outFreq;
    logic [11:0] timer;
    logic gateOn;
    logic brakeOn;
    logic [6:0] brakeLevel;
    logic brakeQuick;
    logic awHeld;
    logic [7:0] awAddr;
    logic wHeld;
    logic [31:0] wData;
    logic [3:0] wStrb;
    logic awRdy;
    logic wRdy;
    logic bValid;
    logic [1:0] bResp;
    logic arRdy;
    logic rValid;
    logic [31:0] rData;
    logic [1:0] rResp;
  } fls_st_t;

endpackage

// [fls_tick_div.sv]
`timescale 1ns/10ps
module fls_tick_div #(
  parameter int CYCLES = 2500000
) (
  input wire logic sys_clk, // system clock
  input wire logic reset, // async, active high
  output logic tick // one-cycle pulse every CYCLES clocks
);
  import fls_pkg::*;

  localparam int CW = (CYCLES > 1) ? $clog2(CYCLES) : 1;
  localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

  typedef struct packed {
    logic [CW-1:0] cnt;
    logic tick;
  } fls_div_t;

  fls_div_t s_ff;
  fls_div_t nxt_s;

  if (CYCLES < 1) begin : g_chk
    $error("tick divider needs at least one cycle");
  end

  // free-running count; the pulse is registered so it is glitch free
  always_comb begin
    nxt_s = s_ff;
    nxt_s.tick = (s_ff.cnt == LAST);
    nxt_s.cnt = (s_ff.cnt == LAST) ? '0 : s_ff.cnt + 1'b1;
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign tick = s_ff.tick;
endmodule

// [fls_motor_model.sv]
`timescale 1ns/10ps
// crude motor on the far side: speed follows the drive while gated,
// DC injection stops it, and it coasts down when the output is off
module fls_motor_model
  import fls_pkg::*;
(
  input wire logic sys_clk, // system clock
  input wire logic reset, // async, active high
  input wire logic gateOn, // drive output enabled
  input wire logic brakeActive, // DC current injected
  input wire logic [15:0] outFreq, // drive frequency, 0.1 Hz
  output logic [15:0] speed // shaft speed, 0.1 Hz
);
  typedef struct packed {logic [15:0] speed;} fls_motor_t;
  fls_motor_t state_ff;
  fls_motor_t nxt_state;
  // coasting drops one step a cycle, far quicker than a real load, to keep runs short
  always_comb begin
    nxt_state = state_ff;
    if (brakeActive) nxt_state.speed = FREQ_ZERO;
    else if (gateOn) nxt_state.speed = outFreq;
    else if (state_ff.speed != FREQ_ZERO) nxt_state.speed = state_ff.speed - 16'h0001;
  end
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) state_ff <= '0;
    else state_ff <= nxt_state;
  end
  assign speed = state_ff.speed;
endmodule

// [freq_limit_start_stop_dc_brake_tb.sv]
`timescale 1ns/10ps
module freq_limit_start_stop_dc_brake_tb;
  import fls_pkg::*;
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic runCmd = 1'b0;
  logic brakeEnableInput = 1'b0;
  logic [15:0] refFreq = 16'h0000;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic [7:0] s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h00000000;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [15:0] outFreq, speed;
  logic [6:0] brakeLevel;
  logic gateOn, brakeActive, brakeQuick, s_axi_awready, s_axi_wready;
  logic s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic sawBrake = 1'b0;
  int mismatches = 0;
  int n_checks = 0;
  int cnt;

  // short tick so hold and brake times take tens of cycles
  fls_freq_seq #(.TICK_CYCLES(10)) fls_freq_seq_i (.sys_clk, .reset, .runCmd,
    .brakeEnableInput, .refFreq, .outFreq, .gateOn, .brakeActive, .brakeLevel,
    .brakeQuick, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  fls_motor_model fls_motor_model_i (.sys_clk, .reset, .gateOn, .brakeActive,
    .outFreq, .speed);

  always #2 sys_clk = ~sys_clk;
  // sticky flag so a brief brake pulse is not missed between checks
  always @(posedge sys_clk) if (brakeActive === 1'b1) sawBrake <= 1'b1;

  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // address and data offered together, each dropped once taken
  task axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw;
    logic w;
    aw = 1'b0;
    w = 1'b0;
    @(posedge sys_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(aw && w)) begin
      @(posedge sys_clk);
      if (!aw && s_axi_awready === 1'b1) begin
        aw = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w && s_axi_wready === 1'b1) begin
        w = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    while (s_axi_bvalid !== 1'b1) @(posedge sys_clk);
    chk(32'(s_axi_bresp), 32'(er));
    s_axi_bready <= 1'b0;
  endtask

  // read data compared only when the answer is okay
  task axr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge sys_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge sys_clk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    while (s_axi_rvalid !== 1'b1) @(posedge sys_clk);
    chk(32'(s_axi_rresp), 32'(er));
    if (er == RESP_OKAY) chk(s_axi_rdata, d);
    s_axi_rready <= 1'b0;
  endtask

  // bounded wait for gateOn (0) or brakeActive (1) to reach a level
  task waitSig(input int s, input logic v);
    int i;
    i = 0;
    while ((s == 0 ? gateOn : brakeActive) !== v && i < 3000) begin
      @(posedge sys_clk);
      #1;
      i++;
    end
    chk(32'(s == 0 ? gateOn : brakeActive), 32'(v));
  endtask

  task report_and_stop;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  initial begin
    repeat (20) @(posedge sys_clk);
    reset <= 1'b0;
    axr(OFS_HIGH_LIM, 32'h1388, RESP_OKAY);
    axr(OFS_START_FREQ, 32'h5, RESP_OKAY);
    axw(OFS_HIGH_LIM, 32'hFFFF, RESP_OKAY);
    axr(OFS_HIGH_LIM, 32'h1388, RESP_OKAY);
    axw(OFS_BRK_LEVEL, 32'h7F, RESP_OKAY);
    axr(OFS_BRK_LEVEL, 32'h64, RESP_OKAY);
    axw(OFS_BRK_TIME, 32'hFFF, RESP_OKAY);
    axr(OFS_BRK_TIME, 32'hBB8, RESP_OKAY);
    axw(8'h34, 32'h1, RESP_SLVERR);
    axw(OFS_STATUS, 32'h1, RESP_SLVERR);
    axr(8'h34, 32'h0, RESP_SLVERR);
    $display("test registers done");
    // high 5.0 Hz kept above low, start 2.0 and stop 1.0
    axw(OFS_HIGH_LIM, 32'h32, RESP_OKAY);
    axw(OFS_START_FREQ, 32'h14, RESP_OKAY);
    axw(OFS_START_HOLD, 32'h3, RESP_OKAY);
    axw(OFS_STOP_FREQ, 32'hA, RESP_OKAY);
    axw(OFS_BRK_START, 32'h1E, RESP_OKAY);
    axw(OFS_BRK_TIME, 32'h5, RESP_OKAY);
    axw(OFS_CTRL, 32'h4, RESP_OKAY);
    @(posedge sys_clk) refFreq <= 16'h64;
    runCmd <= 1'b1;
    waitSig(0, 1'b1);
    chk(32'(outFreq), 32'h14);
    repeat (15) @(posedge sys_clk);
    #1 chk(32'(outFreq), 32'h14);
    repeat (200) @(posedge sys_clk);
    #1 chk(32'(outFreq), 32'h32);
    $display("test start and clamp done");
    @(posedge sys_clk) runCmd <= 1'b0;
    waitSig(1, 1'b1);
    chk(32'(brakeLevel), 32'h50);
    chk(32'(brakeQuick), 32'h1);
    cnt = 0;
    while (brakeActive === 1'b1 && cnt < 500) begin
      @(posedge sys_clk);
      #1 cnt++;
    end
    chk(32'(cnt >= 40 && cnt <= 60), 32'h1);
    chk(32'(speed), 32'h0);
    chk(32'(gateOn), 32'h0);
    $display("test timed brake done");
    @(posedge sys_clk) brakeEnableInput <= 1'b1;
    waitSig(1, 1'b1);
    repeat (100) @(posedge sys_clk);
    #1 chk(32'(brakeActive), 32'h1);
    @(posedge sys_clk) brakeEnableInput <= 1'b0;
    waitSig(1, 1'b0);
    $display("test external brake done");
    axw(OFS_BRK_TIME, 32'h0, RESP_OKAY);
    axw(OFS_START_FREQ, 32'hA, RESP_OKAY);
    axw(OFS_STOP_FREQ, 32'h14, RESP_OKAY);
    @(posedge sys_clk) refFreq <= 16'h0F;
    runCmd <= 1'b1;
    repeat (50) @(posedge sys_clk);
    #1 chk(32'(gateOn), 32'h0);
    @(posedge sys_clk) refFreq <= 16'h1E;
    waitSig(0, 1'b1);
    sawBrake = 1'b0;
    @(posedge sys_clk) runCmd <= 1'b0;
    waitSig(0, 1'b0);
    chk(32'(sawBrake), 32'h0);
    $display("test start below stop done");
    axw(OFS_START_FREQ, 32'h0, RESP_OKAY);
    axw(OFS_STOP_FREQ, 32'h0, RESP_OKAY);
    @(posedge sys_clk) runCmd <= 1'b1;
    waitSig(0, 1'b1);
    chk(32'(outFreq), 32'(VF_MIN_FREQ));
    @(posedge sys_clk) runCmd <= 1'b0;
    waitSig(0, 1'b0);
    $display("test zero start and stop done");
    report_and_stop;
  end

  // the whole sequence needs about 600 cycles
  initial begin
    repeat (20000) @(posedge sys_clk);
    mismatches++;
    report_and_stop;
  end
endmodule
